/* File: tb/major_state_seq_asserts.sv */
// port checks bound to the sequencer
`timescale 1ns/100ps
`default_nettype none
module major_state_seq_asserts #(
	parameter int WORD_W = 12
) (
	input wire logic              clk_sys,
	input wire logic              resetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pready,
	input wire logic              memIdle,
	input wire logic              memStrobe,
	input wire logic [WORD_W-1:0] memData,
	input wire seq_pkg::instr_s   instr,
	input wire logic              opDone,
	input wire seq_pkg::req_s     req,
	input wire logic [WORD_W-1:0] memoryBufferReg,
	input wire logic              startMemory,
	input wire logic              ioPreset,
	input wire logic              runFlag,
	input wire logic [3:0]        majorState,
	input wire logic [2:0]        timeState,
	input wire logic              breakTransfer,
	input wire logic              displayLoad
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);
	// m leaves its final T5 with c true
	sequence sLeave(logic [3:0] m, logic c);
		(majorState == m && timeState == 3'h5 && c) ##1 (timeState != 3'h5);
	endsequence
	// stopped chain starts a cycle
	sequence sCycleStart;
		(timeState == 3'h0) ##1 (timeState == 3'h1);
	endsequence
	a_apb_ready: assert property (
		psel && !penable |=> pready) else $error("late ready");
	a_start_in_ts1: assert property (
		startMemory |-> timeState == 3'h1) else $error("stray start");
	a_cycle_needs_idle: assert property (
		sCycleStart |-> $past(runFlag) && $past(memIdle))
		else $error("busy start");
	a_ts_one_two: assert property (
		timeState == 3'h1 |=> timeState == 3'h2) else $error("ts1 length");
	a_ts2_waits: assert property (
		timeState == 3'h2 && !memStrobe |=> timeState == 3'h2)
		else $error("ts2 early");
	a_ts_three_five: assert property (
		timeState == 3'h3 |=> timeState == 3'h4 ##1 timeState == 3'h5)
		else $error("ts order");
	a_fetch_loads_mb: assert property (
		majorState == seq_pkg::MS_FETCH && timeState == 3'h4
		|-> memoryBufferReg == memData) else $error("fetch word");
	a_recycle_holds: assert property (
		timeState == 3'h5 && !opDone && instr.rotate &&
		majorState == seq_pkg::MS_FETCH |=> timeState == 3'h5)
		else $error("no recycle");
	a_fetch_to_defer: assert property (
		sLeave(seq_pkg::MS_FETCH, instr.indirect && req == 4'h0)
		|-> majorState == seq_pkg::MS_DEFER) else $error("no defer");
	a_wc_to_ca: assert property (
		sLeave(seq_pkg::MS_WC, 1'b1) |-> majorState == seq_pkg::MS_CA)
		else $error("no addr cycle");
	a_ca_to_brk: assert property (
		sLeave(seq_pkg::MS_CA, 1'b1) |-> majorState == seq_pkg::MS_BRK)
		else $error("no break");
	a_brk_pulse: assert property (
		breakTransfer |-> majorState == seq_pkg::MS_BRK ##1 !breakTransfer)
		else $error("break pulse");
	a_preset_pulse: assert property (
		ioPreset |-> !runFlag ##1 !ioPreset [*3]) else $error("preset");
	a_display_exec2: assert property (
		displayLoad |-> $past(majorState) == seq_pkg::MS_EXEC2)
		else $error("display");
endmodule
bind major_state_seq major_state_seq_asserts #(.WORD_W(WORD_W)) u_chk (
	.clk_sys, .resetn, .psel, .penable, .pready, .memIdle, .memStrobe,
	.memData, .instr, .opDone, .req, .memoryBufferReg, .startMemory,
	.ioPreset, .runFlag, .majorState, .timeState, .breakTransfer,
	.displayLoad
);
`default_nettype wire

/* File: tb/mem_model.sv */
// core memory model answering start pulses
`timescale 1ns/100ps
`default_nettype none
module mem_model (
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	input  wire logic        startMemory,
	input  wire logic [11:0] memoryAddressReg,
	output logic             memIdle,
	output logic             memStrobe,
	output logic [11:0]      memData
);
	logic [2:0]  cnt;  // cycle step, 0 when idle
	logic [11:0] addr; // latched address
	logic        tgl;  // toggles so stale data varies
	// seven-step cycle per start pulse
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			cnt <= 3'h0;
			tgl <= 1'b0;
			addr <= 12'h000;
		end else begin
			tgl <= ~tgl;
			if (startMemory)
				cnt <= 3'h1;
			else if (cnt != 3'h0)
				cnt <= cnt + 3'h1; // wraps to idle after step seven
			if (cnt == 3'h1)
				addr <= memoryAddressReg;
		end
	end
	assign memIdle = (cnt == 3'h0);
	assign memStrobe = (cnt == 3'h3);
	// word valid from step two, a step before strobe, else a moving pattern
	assign memData = (cnt >= 3'h2) ? ({addr[5:0], addr[11:6]} ^ 12'h9c6)
		: {6{tgl, ~tgl}};
endmodule
`default_nettype wire

/* File: tb/tb_major_state_seq.sv */
// self-checking bench for the sequencer
`timescale 1ns/100ps
`default_nettype none
`include "seq_map.svh"
module tb_major_state_seq;
	logic            clk_sys = 1'b0;  // 25 MHz system clock
	logic            resetn = 1'b0;   // active low reset
	logic            psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0]     paddr = '0;      // apb byte address
	logic [31:0]     pwdata = '0, prdata, rd;
	logic            pready, pslverr, err;
	seq_pkg::keys_s  keys = '0;       // console keys, high pressed
	logic            modeSwitchAlt = 1'b1, tapeBusy = 1'b0, opDone = 1'b1;
	logic [11:0]     addressSwitches = '0, dataSwitches = '0;
	seq_pkg::instr_s instr = '0;      // decoded instruction class
	seq_pkg::req_s   req = '0;        // break and interrupt requests
	logic            memIdle, memStrobe, startMemory, ioPreset, runFlag;
	logic [11:0]     memData, memoryAddressReg, memoryBufferReg;
	logic            altMode, wordCountInc, curAddrInc, breakTransfer;
	logic            tapeTransfer, displayLoad;
	logic [3:0]      majorState;
	logic [2:0]      timeState;
	int              failures = 0, checks_done = 0, cycles = 0, n;
	int              nStart = 0, nPreset = 0, nWc = 0, nCa = 0;
	int              nBrk = 0, nTape = 0, nDisp = 0;
	// short console steps
	major_state_seq #(.CONS_CYC(4)) u_dut (
		.clk_sys, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .keys, .modeSwitchAlt,
		.addressSwitches, .dataSwitches, .tapeBusy, .memIdle, .memStrobe,
		.memData, .instr, .opDone, .req, .memoryAddressReg,
		.memoryBufferReg, .startMemory, .ioPreset, .runFlag, .altMode,
		.majorState, .timeState, .wordCountInc, .curAddrInc,
		.breakTransfer, .tapeTransfer, .displayLoad
	);
	mem_model u_mem (
		.clk_sys, .resetn, .startMemory, .memoryAddressReg, .memIdle,
		.memStrobe, .memData
	);
	always #20 clk_sys = ~clk_sys;
	// pulse counters and the hang limit
	always @(posedge clk_sys) begin
		nStart += (startMemory === 1'b1);
		nPreset += (ioPreset === 1'b1);
		nWc += (wordCountInc === 1'b1);
		nCa += (curAddrInc === 1'b1);
		nBrk += (breakTransfer === 1'b1);
		nTape += (tapeTransfer === 1'b1);
		nDisp += (displayLoad === 1'b1);
		cycles++;
		if (cycles == 6000) begin
			failures++;
			test_done();
		end
	end
	task check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task endTest(input string name);
		$display("test %s finished", name);
	endtask
	task test_done;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// memory contents as the model serves them
	function automatic logic [11:0] memf(input logic [11:0] a);
		return {a[5:0], a[11:6]} ^ 12'h9c6;
	endfunction
	// one apb transfer, held until pready
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] r, output logic e);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1);
		check(32'(n), 32'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// press a key for chain and cycle, then release
	task press(input logic [5:0] k);
		@(posedge clk_sys);
		keys <= seq_pkg::keys_s'(k);
		repeat (40) @(posedge clk_sys);
		keys <= '0;
		repeat (40) @(posedge clk_sys);
	endtask
	// wait for the major state to change, then compare it
	task nextMajor(input logic [3:0] exp);
		logic [3:0] m0;
		@(negedge clk_sys);
		m0 = majorState;
		for (n = 0; n < 300 && majorState === m0; n++) @(negedge clk_sys);
		check(32'(majorState), 32'(exp));
	endtask
	initial begin
		repeat (2) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (40) @(posedge clk_sys);
		check(32'(altMode), 32'h0);
		check(32'(nPreset), 32'h1);
		apb(1'b0, `INSTR_OFS, '0, rd, err);
		check(32'(rd[11:9]), 32'h7);
		endTest("power-on");
		apb(1'b0, `CTRL_OFS, '0, rd, err);
		check(rd, 32'(`CTRL_RESET));
		apb(1'b1, `CTRL_OFS, 32'h3, rd, err);
		apb(1'b0, `CTRL_OFS, '0, rd, err);
		check(rd, 32'h3);
		apb(1'b1, 12'h100, 32'h1, rd, err);
		check(32'(err), 32'h1);
		apb(1'b0, 12'h100, '0, rd, err);
		check(32'(err), 32'h1);
		check(rd, 32'h0);
		apb(1'b1, `CTRL_OFS, 32'h2, rd, err); // auto on, interrupts off
		endTest("apb");
		addressSwitches <= 12'h0a5;
		dataSwitches <= 12'h5a3;
		press(6'h10);
		check(32'(memoryAddressReg), 32'h0a5);
		check(32'(memoryBufferReg), 32'h5a3);
		check(32'(runFlag), 32'h0);
		check(32'(nStart), 32'h1);
		apb(1'b0, `STATUS_OFS, '0, rd, err);
		check(32'(rd[10]), 32'h0);
		apb(1'b0, `INSTR_OFS, '0, rd, err);
		check(rd, 32'h0);
		endTest("fill");
		// a long hold must give exactly one manual cycle
		addressSwitches <= 12'h123;
		press(6'h08);
		check(32'(memoryBufferReg), 32'(memf(12'h123)));
		check(32'(nStart), 32'h2);
		tapeBusy <= 1'b1;
		addressSwitches <= 12'h3ff;
		press(6'h10);
		tapeBusy <= 1'b0;
		check(32'(memoryAddressReg), 32'h123);
		check(32'(nStart), 32'h2);
		endTest("examine");
		addressSwitches <= 12'h040;
		dataSwitches <= 12'h777;
		press(6'h04);
		check(32'(nStart), 32'h4);
		check(32'(memoryAddressReg), 32'h041);
		check(32'(memoryBufferReg), 32'(memf(12'h041)));
		endTest("fill-step");
		for (int m = 0; m < 2; m++) begin
			modeSwitchAlt <= m[0];
			press(6'h20);
			check(32'(altMode), 32'(m));
			check(32'(nPreset), 32'(2 + m));
			check(32'(memoryAddressReg), 32'h0);
			check(32'({nStart[7:0], majorState}), 32'h40);
		end
		endTest("preset");
		apb(1'b1, `CTRL_OFS, 32'h1, rd, err);
		@(posedge clk_sys);
		instr <= 9'h180;
		keys <= 6'h01;
		nextMajor(seq_pkg::MS_FETCH);
		keys <= '0;
		nextMajor(seq_pkg::MS_DEFER);
		nextMajor(seq_pkg::MS_EXEC);
		nextMajor(seq_pkg::MS_FETCH);
		instr <= 9'h1c0;
		nextMajor(seq_pkg::MS_DEFER);
		nextMajor(seq_pkg::MS_FETCH);
		instr <= 9'h083;
		nextMajor(seq_pkg::MS_EXEC);
		nextMajor(seq_pkg::MS_EXEC2);
		nextMajor(seq_pkg::MS_FETCH);
		@(negedge clk_sys);
		check(32'(nDisp), 32'h1);
		instr <= '0;
		req <= 4'h6;
		nextMajor(seq_pkg::MS_WC);
		nextMajor(seq_pkg::MS_CA);
		nextMajor(seq_pkg::MS_BRK);
		req <= 4'h0;
		nextMajor(seq_pkg::MS_FETCH);
		check(32'({nWc[7:0], nCa[7:0], nBrk[7:0]}), 32'h010101);
		req <= 4'h1;
		nextMajor(seq_pkg::MS_TBRK);
		req <= 4'h0;
		nextMajor(seq_pkg::MS_FETCH);
		check(32'(nTape), 32'h1);
		req <= 4'h8;
		nextMajor(seq_pkg::MS_INTR);
		req <= 4'h0;
		for (n = 0; n < 40 && timeState !== 3'h4; n++) @(negedge clk_sys);
		check(32'(memoryAddressReg), 32'(`INT_ADDR));
		nextMajor(seq_pkg::MS_FETCH);
		instr <= 9'h020;
		opDone <= 1'b0;
		for (n = 0; n < 40 && timeState !== 3'h5; n++) @(negedge clk_sys);
		repeat (10) @(negedge clk_sys);
		check(32'(timeState), 32'h5);
		@(posedge clk_sys);
		opDone <= 1'b1;
		for (n = 0; n < 6 && timeState === 3'h5; n++) @(negedge clk_sys);
		check(32'(timeState == 3'h5), 32'h0);
		endTest("run");
		// mid-run reset, mode switch left at alternate
		@(posedge clk_sys);
		resetn <= 1'b0;
		instr <= '0;
		@(negedge clk_sys);
		check(32'({runFlag, majorState}), 32'h0);
		@(posedge clk_sys);
		resetn <= 1'b1;
		repeat (40) @(posedge clk_sys);
		check(32'({altMode, runFlag}), 32'h0);
		endTest("reset");
		test_done();
	end
endmodule
`default_nettype wire

/* File: verilog/major_state_seq.sv */
// console chain and major state sequencer
// How it works
// - fetch loads word into instruction and buffer
// - rotate, multiply, slow sample repeat state five
// - indirect enters defer; native jump returns fetch
// - execute sets address, reads operand, repeats five
// - second execute only alternate mode set/display
// - interrupt saves fields, forces address, loads that address into pc
// - three-cycle break: word count, then address
// - break state moves word memory to bus
// - tape break moves word to tape buffer
// - press starts chain only when stopped, idle
// - two timed console states, two microseconds each
// - final pulse sets run and cycle done unless preset
// - first pulse clears skip, half, majors unless continue
// - preset second pulse clears registers, peripherals
// - preset final pulse sets mode, field flags
// - preset forces instruction high bits to ones
// - power-on preset forces native mode
// - fill/exam load address, run, suppress next
// - state three loads data switches or memory
// - fill/exam state five clears run, auto
// - fill-step flags, reload address, store data
// - after fill-step release, step-examine increments address
// - cycle starts on run, done, memory idle
`timescale 1ns/100ps
`default_nettype none
`include "seq_map.svh"
module major_state_seq #(
	parameter int WORD_W    = 12,
	parameter int CONS_CYC  = `CONSOLE_CYCLES
) (
	input  wire logic              clk_sys,
	input  wire logic              resetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire seq_pkg::keys_s    keys,
	input  wire logic              modeSwitchAlt,
	input  wire logic [WORD_W-1:0] addressSwitches,
	input  wire logic [WORD_W-1:0] dataSwitches,
	input  wire logic              tapeBusy,
	input  wire logic              memIdle,
	input  wire logic              memStrobe,
	input  wire logic [WORD_W-1:0] memData,
	input  wire seq_pkg::instr_s   instr,
	input  wire logic              opDone,
	input  wire seq_pkg::req_s     req,
	output logic [WORD_W-1:0]      memoryAddressReg,
	output logic [WORD_W-1:0]      memoryBufferReg,
	output logic                   startMemory,
	output logic                   ioPreset,
	output logic                   runFlag,
	output logic                   altMode,
	output logic [3:0]             majorState,
	output logic [2:0]             timeState,
	output logic                   wordCountInc,
	output logic                   curAddrInc,
	output logic                   breakTransfer,
	output logic                   tapeTransfer,
	output logic                   displayLoad
);
	localparam int CW = $clog2(CONS_CYC + 1);
	localparam logic [CW-1:0] CONS_LAST = CW'(CONS_CYC - 1);

	// reset release through two flops
	logic rstMeta_q;
	logic rstn;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rstMeta_q <= 1'b0;
			rstn      <= 1'b0;
		end else begin
			rstMeta_q <= 1'b1;
			rstn      <= rstMeta_q;
		end
	end

	// apb side state
	logic [1:0]        ctrl_q;       // interrupt enable, auto switch
	logic [31:0]       prdata_q;
	logic              pready_q;
	logic              pslverr_q;
	// processor state
	seq_pkg::major_e   major_q;      // current major state
	logic [2:0]        ts_q;         // time state, 0 = stopped
	logic              run_q;
	logic              cycleDone_q;
	logic [WORD_W-1:0] ma_q;
	logic [WORD_W-1:0] mb_q;
	logic [WORD_W-1:0] ir_q;
	logic [WORD_W-1:0] pc_q;
	logic              skip_q;
	logic              half_q;
	logic              alt_q;        // alternate instruction mode
	logic [3:0]        fields_q;     // data, save, buffer, instr field
	logic [3:0]        savedF_q;     // fields saved on interrupt
	logic              noNext_q;     // manual cycle, no next major
	logic              fillStep_q;
	logic              stepExam_q;
	logic              stepPend_q;   // step-examine waits for release
	logic              auto_q;
	logic              startMem_q;
	logic              ioPreset_q;
	logic              wcInc_q;
	logic              caInc_q;
	logic              brkX_q;
	logic              tapeX_q;
	logic              disp_q;

	// apb answers in the first access cycle
	logic setup;
	logic known;
	assign setup = psel && !penable;
	assign known = (paddr == `CTRL_OFS) || (paddr == `STATUS_OFS) ||
		(paddr == `ADDR_OFS) || (paddr == `BUF_OFS) ||
		(paddr == `INSTR_OFS) || (paddr == `PC_OFS);

	// read data captured at setup, from a flop
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			prdata_q  <= 32'h0;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= setup;
			pslverr_q <= setup && !known;
			if (setup && !pwrite) begin
				case (paddr)
					`CTRL_OFS:   prdata_q <= {30'h0, ctrl_q};
					`STATUS_OFS: prdata_q <= {16'h0, run_q, cycleDone_q,
						alt_q, fillStep_q, stepExam_q, auto_q, skip_q,
						half_q, 1'b0, ts_q, major_q};
					`ADDR_OFS:   prdata_q <= 32'(ma_q);
					`BUF_OFS:    prdata_q <= 32'(mb_q);
					`INSTR_OFS:  prdata_q <= 32'(ir_q);
					`PC_OFS:     prdata_q <= 32'(pc_q);
					default:     prdata_q <= 32'h0;
				endcase
			end else if (setup) begin
				prdata_q <= 32'h0;
			end
		end
	end

	// control register written at the access edge
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ctrl_q <= `CTRL_RESET;
		end else if (psel && penable && pready_q && pwrite &&
			paddr == `CTRL_OFS) begin
			ctrl_q <= pwdata[1:0];
		end
	end

	// two-flop switch synchroniser
	seq_pkg::keys_s keyMeta_q;
	seq_pkg::keys_s keySync_q;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			keyMeta_q <= '0;
			keySync_q <= '0;
		end else begin
			keyMeta_q <= keys;
			keySync_q <= keyMeta_q;
		end
	end

	// press detect and held state
	logic             anyKey;
	logic             held_q;       // console state zero, until release
	logic             powerOn_q;    // preset pending from power-on
	logic             powerCause_q; // current preset came from power
	seq_pkg::keys_s   sel_q;        // key that started the chain
	seq_pkg::console_e cs_q;
	logic [CW-1:0]    cnt_q;
	logic             p0;
	logic             p1;
	logic             p2;
	logic             go;
	assign anyKey = |keySync_q;
	// a press counts only when stopped and tape idle
	assign go = cs_q == seq_pkg::CS_IDLE && !run_q && !tapeBusy;
	assign p0 = go && ((anyKey && !held_q) || powerOn_q);
	assign p1 = cs_q == seq_pkg::CS_ONE && cnt_q == CONS_LAST;
	assign p2 = cs_q == seq_pkg::CS_TWO && cnt_q == CONS_LAST;

	// held flag ignores bounces until release
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			held_q       <= 1'b0;
			powerOn_q    <= 1'b1;
			powerCause_q <= 1'b0;
			sel_q        <= '0;
		end else begin
			if (p0) begin
				held_q       <= anyKey;
				powerOn_q    <= 1'b0;
				powerCause_q <= powerOn_q;
				sel_q        <= keySync_q;
				if (powerOn_q) begin
					sel_q        <= '0;
					sel_q.preset <= 1'b1;
				end
			end else if (!anyKey) begin
				held_q <= 1'b0;
			end
		end
	end

	// console chain: states one and two each last one console step
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cs_q  <= seq_pkg::CS_IDLE;
			cnt_q <= '0;
		end else begin
			cnt_q <= (p0 || p1 || p2) ? '0 : cnt_q + CW'(1);
			case (cs_q)
				seq_pkg::CS_IDLE: if (p0) cs_q <= seq_pkg::CS_ONE;
				seq_pkg::CS_ONE:  if (p1) cs_q <= seq_pkg::CS_TWO;
				seq_pkg::CS_TWO:  if (p2) cs_q <= seq_pkg::CS_IDLE;
				default:          cs_q <= seq_pkg::CS_IDLE;
			endcase
		end
	end

	// processor timing, one time state per clock except T2 waiting on strobe and a recycled T5
	logic begin1;
	logic tp1;
	logic tp2;
	logic tp3;
	logic tp5;
	logic recycle;
	logic stepGo;
	logic fillLike;
	logic manual;
	assign begin1 = run_q && cycleDone_q && memIdle && ts_q == 3'h0;
	assign tp1 = ts_q == 3'h1;
	assign tp2 = ts_q == 3'h2 && memStrobe; // strobe from memory ends T2
	assign tp3 = ts_q == 3'h3;
	assign tp5 = ts_q == 3'h5 && !recycle;
	assign fillLike = sel_q.fill || sel_q.exam || sel_q.fillStep;
	assign manual = noNext_q;
	// long ops hold T5, fast sample excluded
	assign recycle = !manual && !opDone &&
		(major_q == seq_pkg::MS_FETCH || major_q == seq_pkg::MS_EXEC) &&
		(instr.rotate || instr.multiplyInstr ||
		(instr.sampleInstr && !instr.fastSample));
	assign stepGo = stepPend_q && !held_q && !run_q &&
		cs_q == seq_pkg::CS_IDLE;

	// time state counter
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ts_q <= 3'h0;
		end else if (begin1) begin
			ts_q <= 3'h1;
		end else if (tp5) begin
			ts_q <= 3'h0;
		end else if (ts_q == 3'h2) begin
			if (memStrobe) ts_q <= 3'h3;
		end else if (ts_q != 3'h0 && ts_q != 3'h5) begin
			ts_q <= ts_q + 3'h1;
		end
	end

	// run, cycle done and manual-cycle flags
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			run_q       <= 1'b0;
			cycleDone_q <= 1'b0;
			noNext_q    <= 1'b0;
			stepPend_q  <= 1'b0;
			stepExam_q  <= 1'b0;
		end else begin
			if (begin1) cycleDone_q <= 1'b0;
			if (tp5) cycleDone_q <= 1'b1;
			if (p2 && !sel_q.preset) begin
				run_q       <= 1'b1;
				cycleDone_q <= 1'b1;
				noNext_q    <= fillLike;
			end
			if (tp5 && manual) begin
				run_q      <= 1'b0;
				noNext_q   <= 1'b0;
				stepExam_q <= 1'b0;
				if (fillStep_q) begin
					stepPend_q <= 1'b1;
					stepExam_q <= 1'b1;
				end
			end
			if (stepGo) begin
				stepPend_q  <= 1'b0;
				run_q       <= 1'b1;
				cycleDone_q <= 1'b1;
				noNext_q    <= 1'b1;
			end
			if (p1 && sel_q.preset) begin
				run_q    <= 1'b0;
				noNext_q <= 1'b0;
			end
		end
	end

	// fill-step and auto flags
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			fillStep_q <= 1'b0;
			auto_q     <= 1'b0;
		end else begin
			if (p1 && sel_q.fillStep) begin
				fillStep_q <= 1'b1;
				auto_q     <= ctrl_q[`CTRL_AUTO_BIT];
			end
			if (tp5 && manual) begin
				fillStep_q <= 1'b0;
				auto_q     <= 1'b0;
			end
			if (p1 && sel_q.preset) auto_q <= 1'b0;
		end
	end

	// next major state chosen at the close of T5
	seq_pkg::major_e nextMajor;
	always_comb begin
		nextMajor = seq_pkg::MS_FETCH;
		case (major_q)
			seq_pkg::MS_FETCH:
				if (instr.indirect) nextMajor = seq_pkg::MS_DEFER;
				else if (instr.memRef) nextMajor = seq_pkg::MS_EXEC;
			seq_pkg::MS_DEFER:
				if (!instr.jump8) nextMajor = seq_pkg::MS_EXEC;
			seq_pkg::MS_EXEC:
				if (alt_q && instr.setOrDisplay)
					nextMajor = seq_pkg::MS_EXEC2;
			seq_pkg::MS_WC:  nextMajor = seq_pkg::MS_CA;
			seq_pkg::MS_CA:  nextMajor = seq_pkg::MS_BRK;
			default:         nextMajor = seq_pkg::MS_FETCH;
		endcase
		// breaks, interrupts at instruction boundary
		if (nextMajor == seq_pkg::MS_FETCH) begin
			if (req.tapeRequest) nextMajor = seq_pkg::MS_TBRK;
			else if (req.brkRequest)
				nextMajor = req.brkThree ? seq_pkg::MS_WC : seq_pkg::MS_BRK;
			else if (ctrl_q[`CTRL_INTEN_BIT] && req.intRequest)
				nextMajor = seq_pkg::MS_INTR;
		end
	end

	// major state, skip and half-word flags
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			major_q <= seq_pkg::MS_NONE;
			skip_q  <= 1'b0;
			half_q  <= 1'b0;
		end else begin
			if (p0 && !keySync_q.continueSwitch) begin
				major_q <= seq_pkg::MS_NONE;
				skip_q  <= 1'b0;
				half_q  <= 1'b0;
			end else if (p2 && (sel_q.start || sel_q.continueSwitch) &&
				major_q == seq_pkg::MS_NONE) begin
				major_q <= seq_pkg::MS_FETCH;
			end else if (tp3 && major_q == seq_pkg::MS_FETCH && !manual) begin
				skip_q <= 1'b0;
				half_q <= 1'b0;
			end else if (tp5 && !manual) begin
				major_q <= nextMajor;
			end
			if (p1 && sel_q.preset) begin
				major_q <= seq_pkg::MS_NONE;
				skip_q  <= 1'b0;
				half_q  <= 1'b0;
			end
		end
	end

	// address, buffer, instruction and program counter
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ma_q <= '0;
			mb_q <= '0;
			ir_q <= '0;
			pc_q <= '0;
		end else if (p1 && sel_q.preset) begin
			ma_q <= '0;
			mb_q <= '0;
			pc_q <= '0;
			ir_q[WORD_W-1 -: 3] <= 3'h7;
		end else if (p2 && fillLike) begin
			ma_q <= addressSwitches;
		end else if (p2 && sel_q.start) begin
			ma_q <= pc_q;
		end else if (manual) begin
			if (tp1 && stepExam_q) ma_q <= ma_q + WORD_W'(1);
			if (tp2) ir_q <= '0;
			if (tp3) mb_q <= fillStep_q || sel_q.fill ?
				dataSwitches : memData;
		end else begin
			case (major_q)
				seq_pkg::MS_FETCH: begin
					if (tp1) ma_q <= pc_q;
					if (tp2) pc_q <= ma_q + WORD_W'(1);
					if (tp3) begin
						ir_q <= memData;
						mb_q <= memData;
					end
					if (tp5 && (instr.indirect || instr.memRef)) ma_q <= mb_q;
				end
				seq_pkg::MS_DEFER: begin
					if (tp3) mb_q <= memData;
					if (tp5 && instr.jump8) pc_q <= mb_q;
					if (tp5 && !instr.jump8) ma_q <= mb_q;
				end
				seq_pkg::MS_EXEC, seq_pkg::MS_EXEC2: begin
					if (tp3) mb_q <= memData;
					if (tp2 && major_q == seq_pkg::MS_EXEC2) ma_q <= mb_q;
				end
				seq_pkg::MS_INTR: begin
					if (tp1) ma_q <= `INT_ADDR;
					if (tp2) pc_q <= ma_q;
				end
				default: ;
			endcase
		end
	end

	// mode and memory field flags
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			alt_q    <= 1'b0;
			fields_q <= 4'h0;
			savedF_q <= 4'h0;
		end else begin
			if (p1 && sel_q.preset) savedF_q <= 4'h0;
			if (p2 && sel_q.preset) begin
				alt_q    <= powerCause_q ? 1'b0 : modeSwitchAlt;
				fields_q <= 4'hf;
			end
			if (tp1 && major_q == seq_pkg::MS_INTR && !manual) begin
				savedF_q <= fields_q;
				fields_q <= 4'h0;
			end
		end
	end

	// one-clock event pulses
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			startMem_q <= 1'b0;
			ioPreset_q <= 1'b0;
			wcInc_q    <= 1'b0;
			caInc_q    <= 1'b0;
			brkX_q     <= 1'b0;
			tapeX_q    <= 1'b0;
			disp_q     <= 1'b0;
		end else begin
			startMem_q <= begin1;
			ioPreset_q <= p1 && sel_q.preset;
			wcInc_q    <= tp3 && major_q == seq_pkg::MS_WC;
			caInc_q    <= tp3 && major_q == seq_pkg::MS_CA;
			brkX_q     <= tp3 && major_q == seq_pkg::MS_BRK;
			tapeX_q    <= tp3 && major_q == seq_pkg::MS_TBRK;
			disp_q     <= tp5 && !manual && major_q == seq_pkg::MS_EXEC2 &&
				instr.displayCharInstr;
		end
	end

	// outputs straight from flops
	assign prdata           = prdata_q;
	assign pready           = pready_q;
	assign pslverr          = pslverr_q;
	assign memoryAddressReg = ma_q;
	assign memoryBufferReg  = mb_q;
	assign startMemory      = startMem_q;
	assign ioPreset         = ioPreset_q;
	assign runFlag          = run_q;
	assign altMode          = alt_q;
	assign majorState       = major_q;
	assign timeState        = ts_q;
	assign wordCountInc     = wcInc_q;
	assign curAddrInc       = caInc_q;
	assign breakTransfer    = brkX_q;
	assign tapeTransfer     = tapeX_q;
	assign displayLoad      = disp_q;
endmodule
`default_nettype wire

/* File: verilog/seq_map.svh */
// offsets, field positions, reset values and timing counts of the sequencer
`ifndef SEQ_MAP_SVH
`define SEQ_MAP_SVH
`define CTRL_OFS        12'h000
`define STATUS_OFS      12'h004
`define ADDR_OFS        12'h008
`define BUF_OFS         12'h00c
`define INSTR_OFS       12'h010
`define PC_OFS          12'h014
`define CTRL_INTEN_BIT  0
`define CTRL_AUTO_BIT   1
`define CTRL_RESET      2'h0
`define INT_ADDR        12'h001
`define CLK_PERIOD_NS   40
`define CONSOLE_STEP_NS 2000
`define CONSOLE_CYCLES  (`CONSOLE_STEP_NS / `CLK_PERIOD_NS)
`endif

/* File: verilog/seq_pkg.sv */
// types shared by the console and major state sequencer
package seq_pkg;
	// major states, gray along fetch-defer-execute-exec2
	typedef enum logic [3:0] {
		MS_NONE  = 4'h0,
		MS_FETCH = 4'h1,
		MS_DEFER = 4'h3,
		MS_EXEC  = 4'h2,
		MS_EXEC2 = 4'h6,
		MS_INTR  = 4'h7,
		MS_WC    = 4'h5,
		MS_CA    = 4'h4,
		MS_BRK   = 4'hc,
		MS_TBRK  = 4'hd
	} major_e;
	// console timing states, gray order
	typedef enum logic [1:0] {
		CS_IDLE = 2'h0,
		CS_ONE  = 2'h1,
		CS_TWO  = 2'h3
	} console_e;
	// debounced console control switches
	typedef struct packed {
		logic preset;
		logic fill;
		logic exam;
		logic fillStep;
		logic continueSwitch;
		logic start;
	} keys_s;
	// decoded class of the current instruction
	typedef struct packed {
		logic indirect;
		logic memRef;
		logic jump8;
		logic rotate;
		logic multiplyInstr;
		logic sampleInstr;
		logic fastSample;
		logic setOrDisplay;
		logic displayCharInstr;
	} instr_s;
	// break and interrupt requests
	typedef struct packed {
		logic intRequest;
		logic brkRequest;
		logic brkThree;
		logic tapeRequest;
	} req_s;
endpackage
